//--- rtl/mcs_pkg.sv
// constants and types for the memory select and io decode block
package mcs_pkg;

    // integrated register offsets in io space
    localparam logic [7:0] ADDR_PORT1_DIR    = 8'hE0;
    localparam logic [7:0] ADDR_PORT1_VALUE  = 8'hE1;
    localparam logic [7:0] ADDR_PORT2_DIR    = 8'hE2;
    localparam logic [7:0] ADDR_PORT2_VALUE  = 8'hE3;
    localparam logic [7:0] ADDR_COUNTER_CH0  = 8'hE4;
    localparam logic [7:0] ADDR_COUNTER_CH3  = 8'hE7;
    localparam logic [7:0] ADDR_SERIAL_CTRL  = 8'hE8;
    localparam logic [7:0] ADDR_SERIAL_VALUE = 8'hE9;
    localparam logic [7:0] ADDR_RAM_TOP      = 8'hEA;
    localparam logic [7:0] ADDR_RAM_BOTTOM   = 8'hEB;
    localparam logic [7:0] ADDR_ROM_TOP      = 8'hEC;
    localparam logic [7:0] ADDR_SYS_CONFIG   = 8'hED;
    localparam logic [7:0] ADDR_RESERVED0    = 8'hEE;
    localparam logic [7:0] ADDR_RESERVED1    = 8'hEF;

    // the 16-entry integrated block and its peripheral part
    localparam logic [3:0] BLOCK_HIGH_NIBBLE = 4'hE;
    localparam int         BLOCK_ENTRIES     = 16;
    localparam int         PERIPH_COUNT      = 10;
    localparam int         OWN_COUNT         = 4;

    // processor-core window placement, 64-byte steps
    localparam logic [1:0] CORE_BASE_DEFAULT = 2'h0;
    localparam logic [1:0] CORE_BASE_FORBID  = 2'h3;

    // system configuration field positions
    localparam int SCR_PORT1_COUNTER_BIT = 0;
    localparam int SCR_ROM_EMULATOR_BIT  = 1;
    localparam int SCR_ROM_DISABLE_BIT   = 5;

    // reset values
    localparam logic [7:0] RAM_TOP_RESET    = 8'hFF;
    localparam logic [7:0] RAM_BOTTOM_RESET = 8'hFF;
    localparam logic [7:0] ROM_TOP_RESET    = 8'hFF;
    localparam logic [7:0] SYS_CONFIG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // access sequencer, gray coded along its loop
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_SEL  = 2'b11,
        ST_DONE = 2'b10
    } mcs_state_t;

endpackage

//--- rtl/mcs_chip_select.sv
// combinational ram and rom select generation from the upper address byte
`timescale 1ns/1ns
module mcs_chip_select (
    // upper memory address, A19..A12
    input  wire logic [7:0] memAddrHi,
    // boundaries and options
    input  wire logic [7:0] ramTop,
    input  wire logic [7:0] ramBottom,
    input  wire logic [7:0] romTop,
    input  wire logic       romDisable,
    // selects
    output logic            romSelectN,
    output logic            ramSelectN
);

    logic romHit;
    logic ramHit;

    // no strobe qualifies these, so glitches on address changes are expected
    always_comb
    begin
        romHit = (memAddrHi <= romTop) && !romDisable;
        ramHit = (memAddrHi >= ramBottom) && (memAddrHi <= ramTop)
                 && !romHit;
        romSelectN = !romHit;
        ramSelectN = !ramHit;
    end

endmodule

//--- rtl/mcs_io_decode.sv
// full eight-bit decode of integrated registers, A7..A6 decode of the core window
`timescale 1ns/1ns
module mcs_io_decode (
    // io address A7..A0 and core window base
    input  wire logic [7:0]  ioAddr,
    input  wire logic [1:0]  coreBase,
    // decoded hits
    output logic [15:0]      blockHit,
    output logic             blockAny,
    output logic             coreHit
);

    genvar i;

    // one comparator per entry, E0h..EFh, all eight bits compared
    generate
        for (i = 0; i < mcs_pkg::BLOCK_ENTRIES; i = i + 1)
        begin : g_entry
            assign blockHit[i] = (ioAddr ==
                {mcs_pkg::BLOCK_HIGH_NIBBLE, 4'(i)});
        end
    endgenerate

    // block wins should software ever park the window over it
    always_comb
    begin
        blockAny = |blockHit;
        coreHit  = (ioAddr[7:6] == coreBase) && !blockAny;
    end

endmodule

//--- rtl/mcs_top.sv
// memory chip selects, configuration registers and io address decode
`timescale 1ns/1ns

// Behaviour
// - separate active-low rom and ram selects
// - rom select asserts at or below its boundary, ram select from bottom to top where rom select is not asserted
// - selects decoded combinationally from A19-A12 only
// - boundary registers live at EAh, EBh, ECh
// - configuration bit five disables rom select
// - emulator mode drives internal reads outside
// - otherwise external data bus stays released
// - emulator mode is configuration bit one, EDh
// - io registers fully decoded, no aliases
// - E0h-E3h select parallel port registers
// - E4h-E7h select counter channel controls
// - E8h serial control, E9h serial data
// - core window at 00h, relocatable by 64
// - configuration bit zero routes counters to port1
module mcs_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // cpu memory address, A19..A12
    input  wire logic [7:0] memAddrHi,
    // cpu io access
    input  wire logic [7:0] ioAddr,
    input  wire logic       ioRequestN,
    input  wire logic       rdN,
    input  wire logic       wrN,
    input  wire logic [7:0] cpuWrData,
    // core window placement from the core's io control register
    input  wire logic [1:0] coreBase,
    // read value returned by the selected peripheral
    input  wire logic [7:0] periphRdData,
    // memory selects
    output logic            romSelectN,
    output logic            ramSelectN,
    // peripheral strobes, bit n is register E0h+n
    output logic [9:0]      periphSel,
    output logic            periphRd,
    output logic            periphWr,
    output logic [7:0]      periphWrData,
    // core register window select
    output logic            coreSel,
    // read answer to the cpu
    output logic [7:0]      rdData,
    output logic            rdValid,
    // external data bus drive
    output logic [7:0]      extDataOut,
    output logic            extDataOe,
    // pin routing
    output logic            counterOnPort1
);

    // sequencer and captured access
    mcs_pkg::mcs_state_t state_r;
    mcs_pkg::mcs_state_t state_nxt;
    logic [7:0]          addr_r;
    logic [7:0]          addr_nxt;
    logic [7:0]          wdata_r;
    logic [7:0]          wdata_nxt;
    logic                isRd_r;
    logic                isRd_nxt;
    logic                isWr_r;
    logic                isWr_nxt;

    // configuration registers
    logic [7:0]          ramTop_r;
    logic [7:0]          ramTop_nxt;
    logic [7:0]          ramBottom_r;
    logic [7:0]          ramBottom_nxt;
    logic [7:0]          romTop_r;
    logic [7:0]          romTop_nxt;
    logic [7:0]          sysConfig_r;
    logic [7:0]          sysConfig_nxt;

    // registered outputs
    logic [9:0]          periphSel_r;
    logic [9:0]          periphSel_nxt;
    logic                periphRd_r;
    logic                periphRd_nxt;
    logic                periphWr_r;
    logic                periphWr_nxt;
    logic [7:0]          periphWrData_r;
    logic [7:0]          periphWrData_nxt;
    logic                coreSel_r;
    logic                coreSel_nxt;
    logic [7:0]          rdData_r;
    logic [7:0]          rdData_nxt;
    logic                rdValid_r;
    logic                rdValid_nxt;
    logic [7:0]          extDataOut_r;
    logic [7:0]          extDataOut_nxt;
    logic                extDataOe_r;
    logic                extDataOe_nxt;
    logic                counterOnPort1_r;
    logic                counterOnPort1_nxt;

    // decode results
    logic [15:0]         blockHit;
    logic                blockAny;
    logic                coreHit;
    logic                reqActive;
    logic [7:0]          readValue;

    mcs_chip_select u_chip_select (
        .memAddrHi  (memAddrHi),
        .ramTop     (ramTop_r),
        .ramBottom  (ramBottom_r),
        .romTop     (romTop_r),
        .romDisable (sysConfig_r[mcs_pkg::SCR_ROM_DISABLE_BIT]),
        .romSelectN (romSelectN),
        .ramSelectN (ramSelectN)
    );

    // decode runs on the captured address so strobes never see it move
    mcs_io_decode u_io_decode (
        .ioAddr   (addr_r),
        .coreBase (coreBase),
        .blockHit (blockHit),
        .blockAny (blockAny),
        .coreHit  (coreHit)
    );

    // read value for the captured address inside the integrated block
    always_comb
    begin
        readValue = mcs_pkg::READ_ZERO;
        case (addr_r)
            mcs_pkg::ADDR_RAM_TOP:    readValue = ramTop_r;
            mcs_pkg::ADDR_RAM_BOTTOM: readValue = ramBottom_r;
            mcs_pkg::ADDR_ROM_TOP:    readValue = romTop_r;
            mcs_pkg::ADDR_SYS_CONFIG: readValue = sysConfig_r;
            mcs_pkg::ADDR_RESERVED0:  readValue = mcs_pkg::READ_ZERO;
            mcs_pkg::ADDR_RESERVED1:  readValue = mcs_pkg::READ_ZERO;
            default:
            begin
                if (|blockHit[mcs_pkg::PERIPH_COUNT-1:0])
                begin
                    readValue = periphRdData;
                end
            end
        endcase
    end

    // one access per strobe: the sequencer waits for release before rearming
    always_comb
    begin
        reqActive          = !ioRequestN && (!rdN || !wrN);
        state_nxt          = state_r;
        addr_nxt           = addr_r;
        wdata_nxt          = wdata_r;
        isRd_nxt           = isRd_r;
        isWr_nxt           = isWr_r;
        ramTop_nxt         = ramTop_r;
        ramBottom_nxt      = ramBottom_r;
        romTop_nxt         = romTop_r;
        sysConfig_nxt      = sysConfig_r;
        periphSel_nxt      = '0;
        periphRd_nxt       = 1'b0;
        periphWr_nxt       = 1'b0;
        periphWrData_nxt   = periphWrData_r;
        coreSel_nxt        = 1'b0;
        rdData_nxt         = rdData_r;
        rdValid_nxt        = 1'b0;
        extDataOut_nxt     = extDataOut_r;
        extDataOe_nxt      = extDataOe_r;
        counterOnPort1_nxt =
            sysConfig_r[mcs_pkg::SCR_PORT1_COUNTER_BIT];
        case (state_r)
            mcs_pkg::ST_IDLE:
            begin
                extDataOe_nxt = 1'b0;
                if (reqActive)
                begin
                    addr_nxt  = ioAddr;
                    wdata_nxt = cpuWrData;
                    // a read wins if both strobes are seen together
                    isRd_nxt  = !rdN;
                    isWr_nxt  = rdN && !wrN;
                    state_nxt = mcs_pkg::ST_ADDR;
                end
            end
            mcs_pkg::ST_ADDR:
            begin
                // E0h..E9h map one to one onto the peripheral strobes
                periphSel_nxt    =
                    blockHit[mcs_pkg::PERIPH_COUNT-1:0];
                periphRd_nxt     = isRd_r &&
                    (|blockHit[mcs_pkg::PERIPH_COUNT-1:0]);
                periphWr_nxt     = isWr_r &&
                    (|blockHit[mcs_pkg::PERIPH_COUNT-1:0]);
                periphWrData_nxt = wdata_r;
                coreSel_nxt      = coreHit;
                state_nxt        = mcs_pkg::ST_SEL;
            end
            mcs_pkg::ST_SEL:
            begin
                if (isWr_r)
                begin
                    // reserved addresses fall through and change nothing
                    case (addr_r)
                        mcs_pkg::ADDR_RAM_TOP:    ramTop_nxt    = wdata_r;
                        mcs_pkg::ADDR_RAM_BOTTOM: ramBottom_nxt = wdata_r;
                        mcs_pkg::ADDR_ROM_TOP:    romTop_nxt    = wdata_r;
                        mcs_pkg::ADDR_SYS_CONFIG: sysConfig_nxt = wdata_r;
                        default:                  sysConfig_nxt = sysConfig_r;
                    endcase
                end
                if (isRd_r && blockAny)
                begin
                    rdData_nxt  = readValue;
                    rdValid_nxt = 1'b1;
                    // core-owned reads never leave through this path
                    extDataOut_nxt = readValue;
                    extDataOe_nxt  =
                        sysConfig_r[mcs_pkg::SCR_ROM_EMULATOR_BIT];
                end
                state_nxt = mcs_pkg::ST_DONE;
            end
            mcs_pkg::ST_DONE:
            begin
                if (!reqActive)
                begin
                    extDataOe_nxt = 1'b0;
                    state_nxt     = mcs_pkg::ST_IDLE;
                end
            end
            default:
            begin
                extDataOe_nxt = 1'b0;
                state_nxt     = mcs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r          <= mcs_pkg::ST_IDLE;
            addr_r           <= 8'h00;
            wdata_r          <= 8'h00;
            isRd_r           <= 1'b0;
            isWr_r           <= 1'b0;
            ramTop_r         <= mcs_pkg::RAM_TOP_RESET;
            ramBottom_r      <= mcs_pkg::RAM_BOTTOM_RESET;
            romTop_r         <= mcs_pkg::ROM_TOP_RESET;
            sysConfig_r      <= mcs_pkg::SYS_CONFIG_RESET;
            periphSel_r      <= 10'h000;
            periphRd_r       <= 1'b0;
            periphWr_r       <= 1'b0;
            periphWrData_r   <= 8'h00;
            coreSel_r        <= 1'b0;
            rdData_r         <= 8'h00;
            rdValid_r        <= 1'b0;
            extDataOut_r     <= 8'h00;
            extDataOe_r      <= 1'b0;
            counterOnPort1_r <= 1'b0;
        end
        else
        begin
            state_r          <= state_nxt;
            addr_r           <= addr_nxt;
            wdata_r          <= wdata_nxt;
            isRd_r           <= isRd_nxt;
            isWr_r           <= isWr_nxt;
            ramTop_r         <= ramTop_nxt;
            ramBottom_r      <= ramBottom_nxt;
            romTop_r         <= romTop_nxt;
            sysConfig_r      <= sysConfig_nxt;
            periphSel_r      <= periphSel_nxt;
            periphRd_r       <= periphRd_nxt;
            periphWr_r       <= periphWr_nxt;
            periphWrData_r   <= periphWrData_nxt;
            coreSel_r        <= coreSel_nxt;
            rdData_r         <= rdData_nxt;
            rdValid_r        <= rdValid_nxt;
            extDataOut_r     <= extDataOut_nxt;
            extDataOe_r      <= extDataOe_nxt;
            counterOnPort1_r <= counterOnPort1_nxt;
        end
    end

    // selects stay combinational on purpose; everything else is a flop
    assign periphSel      = periphSel_r;
    assign periphRd       = periphRd_r;
    assign periphWr       = periphWr_r;
    assign periphWrData   = periphWrData_r;
    assign coreSel        = coreSel_r;
    assign rdData         = rdData_r;
    assign rdValid        = rdValid_r;
    assign extDataOut     = extDataOut_r;
    assign extDataOe      = extDataOe_r;
    assign counterOnPort1 = counterOnPort1_r;

endmodule

//--- verification/mcs_top_props.sv
// assertion checker for the memory select and io decode block
`timescale 1ns/1ns
module mcs_top_props (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // cpu side
    input wire logic [7:0] memAddrHi,
    input wire logic [7:0] ioAddr,
    input wire logic       ioRequestN,
    input wire logic [7:0] cpuWrData,
    input wire logic [1:0] coreBase,
    input wire logic [7:0] periphRdData,
    // design outputs
    input wire logic       romSelectN,
    input wire logic       ramSelectN,
    input wire logic [9:0] periphSel,
    input wire logic       periphRd,
    input wire logic       periphWr,
    input wire logic [7:0] periphWrData,
    input wire logic       coreSel,
    input wire logic [7:0] rdData,
    input wire logic       rdValid,
    input wire logic [7:0] extDataOut,
    input wire logic       extDataOe
);
    // quiet cycles since the last io request, saturating
    logic [2:0] quietCnt_r;
    logic [2:0] quietCnt_nxt;

    always_comb
    begin
        quietCnt_nxt = quietCnt_r;
        if (!ioRequestN)
            quietCnt_nxt = 3'h0;
        else if (quietCnt_r != 3'h7)
            quietCnt_nxt = quietCnt_r + 3'h1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            quietCnt_r <= 3'h0;
        else
            quietCnt_r <= quietCnt_nxt;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sel_exclusive_a: assert property (romSelectN || ramSelectN)
        else $error("rom and ram selected together");
    // a register write lands three edges after its request
    sel_addr_only_a: assert property (quietCnt_r >= 3'h5 &&
        $stable(memAddrHi) |-> $stable(romSelectN) && $stable(ramSelectN))
        else $error("select moved without address change");
    periph_pulse_a: assert property (periphSel != 10'h000 |->
        $onehot(periphSel) ##1 periphSel == 10'h000)
        else $error("peripheral select not a single pulse");
    periph_map_a: assert property (periphSel != 10'h000 |->
        periphSel == (10'h001 << ($past(ioAddr, 2) - 8'hE0)))
        else $error("peripheral select at wrong address");
    full_decode_a: assert property (rdValid |->
        ($past(ioAddr, 3) >> 4) == 8'h0E)
        else $error("read answer outside integrated block");
    core_window_a: assert property (coreSel |->
        ($past(ioAddr, 2) >> 6) == {6'h00, $past(coreBase)})
        else $error("core window hit at wrong place");
    wr_data_a: assert property (periphWr |->
        periphWrData == $past(cpuWrData, 2))
        else $error("peripheral write data wrong");
    rd_return_a: assert property (periphRd |=>
        rdValid && rdData == $past(periphRdData))
        else $error("peripheral read value not returned");
    oe_only_read_a: assert property ($rose(extDataOe) |-> rdValid)
        else $error("external bus driven without read");
    ext_value_a: assert property (extDataOe && rdValid |->
        extDataOut == rdData)
        else $error("external bus value differs from read");

    cover property (coreSel);
    cover property (extDataOe && rdValid);
    cover property (periphWr);
endmodule

bind mcs_top mcs_top_props u_mcs_top_props (.clk, .rst, .memAddrHi, .ioAddr,
    .ioRequestN, .cpuWrData, .coreBase, .periphRdData, .romSelectN,
    .ramSelectN, .periphSel, .periphRd, .periphWr, .periphWrData,
    .coreSel, .rdData, .rdValid, .extDataOut, .extDataOe);

//--- verification/mcs_mem_model.sv
// external rom and ram devices watching the selects
`timescale 1ns/1ns
module mcs_mem_model (
    // selects from the block
    input wire logic romSelectN,
    input wire logic ramSelectN,
    // which device answers, and a bus fight
    output logic     romActive,
    output logic     ramActive,
    output logic     busFight
);
    assign romActive = romSelectN === 1'h0;
    assign ramActive = ramSelectN === 1'h0;
    // both devices driving data would clash
    assign busFight  = romActive && ramActive;
endmodule

//--- verification/mcs_top_bench.sv
// self-checking bench for the memory select and io decode block
`timescale 1ns/1ns
module mcs_top_bench;
    logic       clk, rst, ioRequestN, rdN, wrN, romSelectN, ramSelectN;
    logic       periphRd, periphWr, coreSel, rdValid, extDataOe, cntP1;
    logic       romAct, ramAct, fight;
    logic [7:0] memAddrHi, ioAddr, cpuWrData, periphRdData;
    logic [7:0] extDataOut, rdData, periphWrData;
    logic [1:0] coreBase;
    logic [9:0] periphSel;
    int         miscompares, compares, ramTop, ramBot, romTop, sysCfg;

    mcs_top u_mcs_top (.clk, .rst, .memAddrHi, .ioAddr, .ioRequestN, .rdN,
        .wrN, .cpuWrData, .coreBase, .periphRdData, .romSelectN, .ramSelectN,
        .periphSel, .periphRd, .periphWr, .periphWrData, .coreSel, .rdData,
        .rdValid, .extDataOut, .extDataOe, .counterOnPort1(cntP1));
    mcs_mem_model u_mcs_mem_model (.romSelectN, .ramSelectN,
        .romActive(romAct), .ramActive(ramAct), .busFight(fight));

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // every upper address byte, checked before any clock edge
    task automatic sweep;
        int rh, mh;
        for (int a = 0; a < 256; a++)
        begin
            @(negedge clk);
            memAddrHi = 8'(a);
            rh = (a <= romTop) && !sysCfg[5];
            mh = (a >= ramBot) && (a <= ramTop) && !rh;
            #1;
            chk("romSelectN", 16'(!rh), 16'(romSelectN));
            chk("ramSelectN", 16'(!mh), 16'(ramSelectN));
            chk("busFight", 16'h0000, 16'(fight));
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic io(logic [7:0] a, logic [7:0] d, bit rd);
        logic [7:0]  pv, ev;
        logic [15:0] es;
        bit          blk, per;
        pv = 8'($urandom);
        blk = a[7:4] == 4'hE;
        per = a >= 8'hE0 && a <= 8'hE9;
        es = per ? 16'h0001 << (a - 8'hE0) : 16'h0000;
        case (a)
            8'hEA: ev = 8'(ramTop);
            8'hEB: ev = 8'(ramBot);
            8'hEC: ev = 8'(romTop);
            8'hED: ev = 8'(sysCfg);
            default: ev = per ? pv : 8'h00;
        endcase
        @(negedge clk);
        ioAddr = a;
        cpuWrData = d;
        periphRdData = pv;
        ioRequestN = 1'h0;
        rdN = !rd;
        wrN = rd;
        // strobes stand for the one cycle after the second edge only
        repeat (2) @(posedge clk);
        #1;
        chk("periphSel", es, 16'(periphSel));
        chk("periphRd", 16'(per && rd), 16'(periphRd));
        chk("periphWr", 16'(per && !rd), 16'(periphWr));
        chk("coreSel", 16'(!blk && a[7:6] == coreBase),
            16'(coreSel));
        if (per && !rd)
            chk("periphWrData", 16'(d), 16'(periphWrData));
        @(posedge clk);
        #1;
        chk("rdValid", 16'(blk && rd), 16'(rdValid));
        if (blk && rd)
            chk("rdData", 16'(ev), 16'(rdData));
        chk("extDataOe", 16'(blk && rd && sysCfg[1]),
            16'(extDataOe));
        if (blk && rd && sysCfg[1])
            chk("extDataOut", 16'(ev), 16'(extDataOut));
        if (!rd)
            case (a)
                8'hEA: ramTop = d;
                8'hEB: ramBot = d;
                8'hEC: romTop = d;
                8'hED: sysCfg = d;
                default: ;
            endcase
        @(negedge clk);
        ioRequestN = 1'h1;
        rdN = 1'h1;
        wrN = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk("extDataOe", 16'h0000, 16'(extDataOe));
        chk("counterOnPort1", 16'(sysCfg[0]), 16'(cntP1));
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        miscompares = 0;
        compares = 0;
        rst = 1'h1;
        {ioRequestN, rdN, wrN} = 3'h7;
        {memAddrHi, ioAddr, cpuWrData, periphRdData} = 32'h0000_0000;
        coreBase = 2'h0;
        {ramTop, ramBot, romTop, sysCfg} = {32'hFF, 32'hFF, 32'hFF, 32'h0};
        void'($urandom(32'h1DDE));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        for (int a = 8'hEA; a <= 8'hEF; a++)
            io(8'(a), 8'h00, 1);
        sweep();
        $display("test reset values done");
        for (int k = 0; k < 4; k++)
        begin
            io(8'hEC, 8'($urandom), 0);
            io(8'hEB, 8'($urandom), 0);
            io(8'hEA, 8'($urandom), 0);
            io(8'hED, (8'($urandom) & 8'hDD) |
                {2'h0, k[1], 3'h0, k[0], 1'h0}, 0);
            for (int a = 8'hE0; a <= 8'hEF; a++)
            begin
                io(8'(a), 8'h00, 1);
                if (a < 8'hEA || a > 8'hED)
                    io(8'(a), 8'($urandom), 0);
            end
            sweep();
            @(negedge clk);
            coreBase = 2'(k % 3);
            io({coreBase, 6'($urandom)}, 8'h00, 1);
            // core mode setup keeps its two hazardous bits clear
            io({coreBase, 6'($urandom)},
                8'($urandom) & 8'h5F, 0);
            io({4'hF, 4'($urandom)}, 8'h00, 1);
            io({4'hD, 4'($urandom)}, 8'($urandom), 0);
            $display("test config %0d done", k);
        end
        report_and_stop();
    end
endmodule
